// ### rxcfg_pkg.sv
package rxcfg_pkg;

    // ************************************************************
    // Register indices, word index bounds and slots
    // ************************************************************
    localparam int unsigned IDX_IRQ_LEVEL = 15;
    localparam int unsigned IDX_FILTER_BW = 16;
    localparam int unsigned IDX_POLY_CENTRE = 17;
    localparam int unsigned IDX_SYNC_CTRL = 18;
    localparam int unsigned IDX_RESERVED = 19;
    localparam int unsigned IDX_STRENGTH = 20;
    localparam int unsigned IDX_OOK_CTRL = 21;
    localparam int unsigned REG_COUNT = 7;
    localparam logic [5:0] WORD_FIRST = 6'(IDX_IRQ_LEVEL);
    localparam logic [5:0] WORD_LAST = 6'(IDX_OOK_CTRL);
    localparam logic [2:0] SLOT_STRENGTH = 3'(IDX_STRENGTH - IDX_IRQ_LEVEL);
    localparam logic [2:0] SLOT_FILTER_BW = 3'(IDX_FILTER_BW - IDX_IRQ_LEVEL);
    localparam logic [2:0] SLOT_POLY_CENTRE = 3'(IDX_POLY_CENTRE - IDX_IRQ_LEVEL);
    localparam logic [2:0] SLOT_SYNC_CTRL = 3'(IDX_SYNC_CTRL - IDX_IRQ_LEVEL);
    localparam logic [2:0] SLOT_OOK_CTRL = 3'(IDX_OOK_CTRL - IDX_IRQ_LEVEL);
    localparam logic [2:0] SLOT_IRQ_LEVEL = 3'h0;

    // ************************************************************
    // Values after reset, lowest index first
    // ************************************************************
    localparam logic [7:0] REG_RESET [REG_COUNT] = '{
        8'h00, 8'h03, 8'h38, 8'h18, 8'h07, 8'h00, 8'h00
    };
    localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned LPF_MSB = 7;
    localparam int unsigned LPF_LSB = 4;
    localparam int unsigned RXBW_MSB = 3;
    localparam int unsigned RXBW_LSB = 0;
    localparam int unsigned CENTRE_MSB = 7;
    localparam int unsigned CENTRE_LSB = 4;
    localparam int unsigned POLY_EN_BIT = 7;
    localparam int unsigned BITSYNC_OFF_BIT = 6;
    localparam int unsigned SYNC_ON_BIT = 5;
    localparam int unsigned SYNC_SIZE_MSB = 4;
    localparam int unsigned SYNC_SIZE_LSB = 3;
    localparam int unsigned SYNC_TOL_MSB = 2;
    localparam int unsigned SYNC_TOL_LSB = 1;
    localparam int unsigned STEP_MSB = 7;
    localparam int unsigned STEP_LSB = 5;
    localparam int unsigned RATE_MSB = 4;
    localparam int unsigned RATE_LSB = 2;
    localparam int unsigned CUTOFF_MSB = 1;
    localparam int unsigned CUTOFF_LSB = 0;

    // ************************************************************
    // Decode tables and counts
    // ************************************************************
    localparam logic [4:0] STEP_HALF_DB [8] = '{
        5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C
    };
    localparam logic [1:0] CUTOFF_WIDE = 2'h3;
    localparam logic [5:0] CUTOFF_DIV_NARROW = 6'h08;
    localparam logic [5:0] CUTOFF_DIV_WIDE = 6'h20;
    localparam int unsigned PERIOD_W = 16;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hFFFF;

endpackage : rxcfg_pkg

// ### rxcfg_sync.sv
module rxcfg_sync
    import rxcfg_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_value,
    output logic [W-1:0] value_q
);

    // ************************************************************
    // Two stage capture, then a stability check
    // ************************************************************
    logic [W-1:0] meta_q;
    logic [W-1:0] safe_q;
    logic [W-1:0] prev_q;
    wire steady = (safe_q == prev_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            safe_q <= '0;
            prev_q <= '0;
            value_q <= '0;
        end else begin
            meta_q <= async_value;
            safe_q <= meta_q;
            prev_q <= safe_q;
            if (steady) begin
                value_q <= prev_q;
            end
        end
    end

endmodule // rxcfg_sync

// ### rxcfg_pacer.sv
module rxcfg_pacer
    import rxcfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic chip_tick,
    input wire logic [2:0] rate_sel,
    output logic dec_pulse_q
);

    // ************************************************************
    // Chip period measure and decrement spacing
    // ************************************************************
    logic [PERIOD_W-1:0] cyc_q;
    logic [PERIOD_W-1:0] period_q;
    logic [PERIOD_W-1:0] sub_q;
    logic [2:0] chips_q;
    logic [4:0] fired_q;

    wire fast = rate_sel[2];
    wire [1:0] sh = rate_sel[1:0];
    wire [2:0] slow_mask = 3'((4'h1 << sh) - 4'h1);
    wire slow_hit = chip_tick && ((chips_q & slow_mask) == slow_mask);
    wire [2:0] fast_sh = 3'({1'h0, sh} + 3'h1);
    wire [PERIOD_W-1:0] interval = period_q >> fast_sh;
    wire [4:0] fire_limit = 5'((6'h01 << fast_sh) - 6'h01);
    wire [PERIOD_W-1:0] sub_next = PERIOD_W'(sub_q + 16'h0001);
    wire fast_hit = !chip_tick && (interval != '0) && (sub_next >= interval) && (fired_q < fire_limit);
    wire dec_d = fast ? (chip_tick || fast_hit) : slow_hit;
    wire [PERIOD_W-1:0] cyc_next = (cyc_q == PERIOD_MAX) ? PERIOD_MAX : PERIOD_W'(cyc_q + 16'h0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= '0;
            period_q <= '0;
            chips_q <= 3'h0;
        end else if (chip_tick) begin
            cyc_q <= '0;
            period_q <= cyc_next;
            chips_q <= 3'(chips_q + 3'h1);
        end else begin
            cyc_q <= cyc_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_q <= '0;
            fired_q <= 5'h00;
        end else if (chip_tick) begin
            sub_q <= '0;
            fired_q <= 5'h00;
        end else if (fast_hit) begin
            sub_q <= '0;
            fired_q <= 5'(fired_q + 5'h01);
        end else begin
            sub_q <= sub_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_pulse_q <= 1'h0;
        end else begin
            dec_pulse_q <= dec_d;
        end
    end

endmodule // rxcfg_pacer

// ### rxcfg_regs.sv
// Implementation choice: the APB slave port.
module rxcfg_regs
    import rxcfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ook_mode,
    input wire logic continuous_mode,
    input wire logic chip_tick,
    input wire logic [7:0] signal_strength_pin,
    output logic [3:0] lowpass_bandwidth_sel,
    output logic [3:0] rx_bandwidth_sel,
    output logic [3:0] polyphase_centre_sel,
    output logic polyphase_enable,
    output logic bit_sync_run,
    output logic sync_detect_enable,
    output logic [5:0] sync_length_bits,
    output logic [3:0] sync_byte_used,
    output logic [1:0] sync_error_tolerance,
    output logic [4:0] onoff_threshold_step,
    output logic onoff_threshold_decrement,
    output logic [5:0] onoff_average_cutoff,
    output logic [7:0] signal_strength_value,
    output logic signal_strength_above_level
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] cfg_q [REG_COUNT];
    logic [7:0] strength_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire [5:0] word_idx = paddr[7:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire in_range = (word_idx >= WORD_FIRST) && (word_idx <= WORD_LAST);
    wire hit = aligned && in_range;
    wire [2:0] slot = 3'(word_idx - WORD_FIRST);
    wire read_only = (slot == SLOT_STRENGTH);
    wire setup = psel && !penable;
    wire access_done = psel && penable && pready_q;
    wire bad_req = !hit || (pwrite && read_only);
    wire wr_en = access_done && pwrite && hit && !read_only && pstrb[0];
    wire [7:0] rd_byte = cfg_q[slot];
    wire [31:0] rd_word = {24'h00_0000, rd_byte};

    // ************************************************************
    // APB answer
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'h0;
            pslverr_q <= 1'h0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && bad_req;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= PRDATA_RESET;
        end else if (setup && !pwrite && hit) begin
            prdata_q <= rd_word;
        end else if (setup) begin
            prdata_q <= PRDATA_RESET;
        end
    end

    // ************************************************************
    // Writable registers, one per slot, except the read-only strength slot
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
            if (gi == int'(SLOT_STRENGTH)) begin : g_ro
                assign cfg_q[gi] = strength_q;
            end else begin : g_rw
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        cfg_q[gi] <= REG_RESET[gi];
                    end else if (wr_en && (slot == 3'(gi))) begin
                        cfg_q[gi] <= pwdata[7:0];
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Signal strength capture
    // ************************************************************
    rxcfg_sync #(
        .W(8)
    ) u_strength_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_value(signal_strength_pin),
        .value_q(strength_q)
    );

    // ************************************************************
    // Field extraction
    // ************************************************************
    wire [7:0] bw_reg = cfg_q[SLOT_FILTER_BW];
    wire [7:0] centre_reg = cfg_q[SLOT_POLY_CENTRE];
    wire [7:0] sync_reg = cfg_q[SLOT_SYNC_CTRL];
    wire [7:0] ook_reg = cfg_q[SLOT_OOK_CTRL];
    wire [7:0] level_reg = cfg_q[SLOT_IRQ_LEVEL];
    wire [3:0] lpf_f = bw_reg[LPF_MSB:LPF_LSB];
    wire [3:0] rxbw_f = bw_reg[RXBW_MSB:RXBW_LSB];
    wire [3:0] centre_f = centre_reg[CENTRE_MSB:CENTRE_LSB];
    wire poly_en_f = sync_reg[POLY_EN_BIT];
    wire bitsync_off_f = sync_reg[BITSYNC_OFF_BIT];
    wire sync_on_f = sync_reg[SYNC_ON_BIT];
    wire [1:0] size_f = sync_reg[SYNC_SIZE_MSB:SYNC_SIZE_LSB];
    wire [1:0] tol_f = sync_reg[SYNC_TOL_MSB:SYNC_TOL_LSB];
    wire [2:0] step_f = ook_reg[STEP_MSB:STEP_LSB];
    wire [2:0] rate_f = ook_reg[RATE_MSB:RATE_LSB];
    wire [1:0] cutoff_f = ook_reg[CUTOFF_MSB:CUTOFF_LSB];

    // ************************************************************
    // Derived receiver controls
    // ************************************************************
    wire poly_d = poly_en_f && ook_mode;
    wire bitsync_d = !(continuous_mode && bitsync_off_f);
    wire [5:0] length_d = {3'(size_f) + 3'h1, 3'h0};
    wire [3:0] bytes_d = {size_f == 2'h3, size_f[1], size_f != 2'h0, 1'h1};
    wire [4:0] step_d = STEP_HALF_DB[step_f];
    wire [5:0] cutoff_d = (cutoff_f == CUTOFF_WIDE) ? CUTOFF_DIV_WIDE : CUTOFF_DIV_NARROW;
    wire above_d = (strength_q > level_reg);

    // ************************************************************
    // Filter selections
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowpass_bandwidth_sel <= REG_RESET[SLOT_FILTER_BW][LPF_MSB:LPF_LSB];
            rx_bandwidth_sel <= REG_RESET[SLOT_FILTER_BW][RXBW_MSB:RXBW_LSB];
            polyphase_centre_sel <= REG_RESET[SLOT_POLY_CENTRE][CENTRE_MSB:CENTRE_LSB];
        end else begin
            lowpass_bandwidth_sel <= lpf_f;
            rx_bandwidth_sel <= rxbw_f;
            polyphase_centre_sel <= centre_f;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            polyphase_enable <= 1'h0;
            bit_sync_run <= 1'h1;
        end else begin
            polyphase_enable <= poly_d;
            bit_sync_run <= bitsync_d;
        end
    end

    // ************************************************************
    // Sync word recognition controls
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_detect_enable <= 1'h0;
            sync_length_bits <= 6'h20;
            sync_byte_used <= 4'hF;
            sync_error_tolerance <= 2'h0;
        end else begin
            sync_detect_enable <= sync_on_f;
            sync_length_bits <= length_d;
            sync_byte_used <= bytes_d;
            sync_error_tolerance <= tol_f;
        end
    end

    // ************************************************************
    // OOK threshold controls
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            onoff_threshold_step <= STEP_HALF_DB[0];
            onoff_average_cutoff <= CUTOFF_DIV_NARROW;
        end else begin
            onoff_threshold_step <= step_d;
            onoff_average_cutoff <= cutoff_d;
        end
    end

    rxcfg_pacer u_pacer (
        .pclk(pclk),
        .presetn(presetn),
        .chip_tick(chip_tick),
        .rate_sel(rate_f),
        .dec_pulse_q(onoff_threshold_decrement)
    );

    // ************************************************************
    // Signal strength outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            signal_strength_value <= 8'h00;
            signal_strength_above_level <= 1'h0;
        end else begin
            signal_strength_value <= strength_q;
            signal_strength_above_level <= above_d;
        end
    end

    // ************************************************************
    // Bus outputs
    // ************************************************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule // rxcfg_regs

// ### rxcfg_asserts.sv
// ************************************************************
// Port checker for the receiver configuration bank
// ************************************************************
module rxcfg_asserts
    import rxcfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ook_mode,
    input wire logic continuous_mode,
    input wire logic polyphase_enable,
    input wire logic bit_sync_run,
    input wire logic sync_detect_enable,
    input wire logic [5:0] sync_length_bits,
    input wire logic [3:0] sync_byte_used,
    input wire logic [1:0] sync_error_tolerance,
    input wire logic [4:0] onoff_threshold_step,
    input wire logic [5:0] onoff_average_cutoff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_one;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready not one cycle after setup");
    property p_ro_write;
        psel && penable && pwrite && paddr == 8'h50 |-> pslverr;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("write to strength not flagged");
    property p_poly;
        !ook_mode |=> !polyphase_enable;
    endproperty
    a_poly: assert property (p_poly) else $error("polyphase on outside ook");
    property p_bitsync;
        !continuous_mode |=> bit_sync_run;
    endproperty
    a_bitsync: assert property (p_bitsync) else $error("bit sync off outside continuous");
    property p_mask;
        (sync_length_bits == 6'h08 && sync_byte_used == 4'h1) || (sync_length_bits == 6'h10 && sync_byte_used == 4'h3)
        || (sync_length_bits == 6'h18 && sync_byte_used == 4'h7) || (sync_length_bits == 6'h20 && sync_byte_used == 4'hF);
    endproperty
    a_mask: assert property (p_mask) else $error("sync length and byte mask disagree");
    property p_step;
        onoff_threshold_step inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C};
    endproperty
    a_step: assert property (p_step) else $error("threshold step out of table");
    property p_cutoff;
        onoff_average_cutoff == 6'h08 || onoff_average_cutoff == 6'h20;
    endproperty
    a_cutoff: assert property (p_cutoff) else $error("averaging cutoff invalid");
    property p_sync_write;
        psel && penable && pready && pwrite && pstrb[0] && paddr == 8'h48 && !pslverr |=> ##1
        {sync_detect_enable, sync_error_tolerance} == {$past(pwdata[5], 2), $past(pwdata[2:1], 2)};
    endproperty
    a_sync_write: assert property (p_sync_write) else $error("sync control write not applied");
endmodule // rxcfg_asserts

bind rxcfg_regs rxcfg_asserts rxcfg_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .ook_mode(ook_mode), .continuous_mode(continuous_mode), .polyphase_enable(polyphase_enable),
    .bit_sync_run(bit_sync_run), .sync_detect_enable(sync_detect_enable), .sync_length_bits(sync_length_bits),
    .sync_byte_used(sync_byte_used), .sync_error_tolerance(sync_error_tolerance),
    .onoff_threshold_step(onoff_threshold_step), .onoff_average_cutoff(onoff_average_cutoff));

// ### rxcfg_regs_tb.sv
// ************************************************************
// Bench for the receiver configuration bank
// ************************************************************
module rxcfg_regs_tb;
    import rxcfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic ook_mode = 1'b0, continuous_mode = 1'b0, chip_tick = 1'b0;
    logic [7:0] signal_strength_pin = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, polyphase_enable, bit_sync_run, sync_detect_enable;
    logic onoff_threshold_decrement, signal_strength_above_level;
    logic [3:0] lowpass_bandwidth_sel, rx_bandwidth_sel, polyphase_centre_sel, sync_byte_used;
    logic [5:0] sync_length_bits, onoff_average_cutoff;
    logic [1:0] sync_error_tolerance;
    logic [4:0] onoff_threshold_step;
    logic [7:0] signal_strength_value;
    int fail_count = 0, comparisons = 0, cycles = 0, dcnt = 0;
    logic [4:0] tcnt = 5'h00;
    logic [7:0] mdl [15:21] = '{8'h00, 8'h03, 8'h38, 8'h18, 8'h07, 8'h00, 8'h00};
    int stp [8] = '{1, 2, 3, 4, 6, 8, 10, 12};

    rxcfg_regs rxcfg_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ook_mode(ook_mode), .continuous_mode(continuous_mode), .chip_tick(chip_tick),
        .signal_strength_pin(signal_strength_pin), .lowpass_bandwidth_sel(lowpass_bandwidth_sel),
        .rx_bandwidth_sel(rx_bandwidth_sel), .polyphase_centre_sel(polyphase_centre_sel),
        .polyphase_enable(polyphase_enable), .bit_sync_run(bit_sync_run), .sync_detect_enable(sync_detect_enable),
        .sync_length_bits(sync_length_bits), .sync_byte_used(sync_byte_used),
        .sync_error_tolerance(sync_error_tolerance), .onoff_threshold_step(onoff_threshold_step),
        .onoff_threshold_decrement(onoff_threshold_decrement), .onoff_average_cutoff(onoff_average_cutoff),
        .signal_strength_value(signal_strength_value), .signal_strength_above_level(signal_strength_above_level));

    initial begin
        forever #10 pclk = ~pclk;
    end

    // ************************************************************
    // Chip ticks, pulse counter, timeout
    // ************************************************************
    always @(posedge pclk) begin
        tcnt <= tcnt + 5'h01;
        chip_tick <= (tcnt == 5'h1F);
        dcnt <= dcnt + 32'(onoff_threshold_decrement);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($urandom), d};
        pstrb <= {3'($urandom), s};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reserved fields keep reset values, cutoff only 00 or 11
    function automatic logic [7:0] legal(input int idx, input logic [7:0] d);
        case (idx)
            17: return {d[7:4], 4'h8};
            18: return {d[7:1], 1'b0};
            19: return 8'h07;
            21: return {d[7:2], {2{d[0]}}};
            default: return d;
        endcase
    endfunction

    // Write with model update, then read back
    task automatic wr_rd(input int idx, input logic [7:0] d, input logic s);
        logic [31:0] rd;
        logic er;
        d = legal(idx, d);
        apb(1'b1, 8'(idx * 4), d, s, rd, er);
        chk(er, idx == 20);
        if (idx != 20 && s) begin
            mdl[idx] = d;
        end
        apb(1'b0, 8'(idx * 4), 8'h00, 1'b1, rd, er);
        chk(rd, idx == 20 ? signal_strength_pin : mdl[idx]);
        chk(er, 1'b0);
    endtask

    task automatic chk_out;
        logic [7:0] c, d;
        c = mdl[18];
        d = mdl[21];
        chk(lowpass_bandwidth_sel, mdl[16][7:4]);
        chk(rx_bandwidth_sel, mdl[16][3:0]);
        chk(polyphase_centre_sel, mdl[17][7:4]);
        chk(polyphase_enable, c[7] & ook_mode);
        chk(bit_sync_run, !(c[6] & continuous_mode));
        chk(sync_detect_enable, c[5]);
        chk(sync_length_bits, 8 * (c[4:3] + 1));
        chk(sync_byte_used, {c[4:3] == 2'h3, c[4], c[4:3] != 2'h0, 1'b1});
        chk(sync_error_tolerance, c[2:1]);
        chk(onoff_threshold_step, stp[d[7:5]]);
        chk(onoff_average_cutoff, d[1:0] == 2'h3 ? 32 : 8);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] rd;
        logic er;
        logic [7:0] v, lv;
        int idx, a;
        void'($urandom(98429));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk_out();
        for (int i = 15; i <= 21; i++) begin
            apb(1'b0, 8'(i * 4), 8'h00, 1'b1, rd, er);
            chk(rd, mdl[i]);
        end
        foreach (mdl[i]) begin
            wr_rd(i, 8'($urandom), 1'b1);
        end
        repeat (40) begin
            idx = 15 + int'($urandom % 7);
            wr_rd(idx, 8'($urandom), idx == 20 || ($urandom % 4) != 0);
        end
        for (int k = 0; k < 4; k++) begin
            lv = k == 0 ? 8'h00 : k == 1 ? 8'h58 : k == 2 ? 8'h41 : 8'hFC;
            apb(1'b1, lv, 8'hA5, 1'b1, rd, er);
            chk(er, 1'b1);
            apb(1'b0, lv, 8'h00, 1'b1, rd, er);
            chk(rd, 32'h0000_0000);
            chk(er, 1'b1);
        end
        for (int i = 0; i < 8; i++) begin
            ook_mode <= 1'($urandom);
            continuous_mode <= 1'($urandom);
            wr_rd(16, 8'($urandom), 1'b1);
            wr_rd(17, 8'($urandom), 1'b1);
            wr_rd(18, {3'($urandom), i[1:0], i[2:1], 1'($urandom)}, 1'b1);
            wr_rd(21, {3'(i), 3'(i), 2'($urandom)}, 1'b1);
            repeat (3) @(posedge pclk);
            chk_out();
            repeat (96) @(posedge pclk);
            a = dcnt;
            repeat (512) @(posedge pclk);
            chk(dcnt - a, i < 4 ? 16 >> i : 16 << (i - 3));
        end
        for (int k = 0; k < 4; k++) begin
            v = 8'($urandom);
            signal_strength_pin <= v;
            repeat (10) @(posedge pclk);
            chk(signal_strength_value, v);
            lv = k == 0 ? v - 8'h01 : k == 1 ? v : 8'($urandom);
            wr_rd(15, lv, 1'b1);
            wr_rd(20, 8'h5A, 1'b1);
            repeat (3) @(posedge pclk);
            chk(signal_strength_above_level, v > lv);
        end
        complete_run();
    end
endmodule // rxcfg_regs_tb
